// ---- core/external_interface.v ----
/*
 * External parallel memory interface: zone chip selects, shaped read and
 * write strobes, ready wait states, bus hold and boot-map mode latch.
 * Assumes one internal requester on clk_sys that holds its request until
 * acc_done; every pin from outside except ext_data_in passes a two-flop synchroniser.
 */
`timescale 1ns/1ps
`include "ext_if_consts.vh"

// Overview of operation
// - Mode high maps zone 7 externally
// - Mode pin latched at reset, software writable
// - Hold request low floats all bus outputs
// - Release bus only after accesses finish
// - Grant low keeps bus tri-stated
// - Drop grant when request released
// - Zone 0/1 select low on access
// - Zone 2 select low on access
// - Zone 6/7 select low on access
// - Write strobe shaped by zone timing
// - Read strobe shaped by zone timing
// - Read and write never together
// - Read-not-write low only during writes
// - Ready sampled synchronous or asynchronous
// - Nineteen bit address bus
// - Sixteen bit shared data bus
module external_interface #(
   parameter AW = `ADDR_W,
   parameter DW = `DATA_W
)(
   input  wire                clk_sys,
   input  wire                sys_rst,
   // Internal request side
   input  wire                acc_req,
   input  wire                acc_write,
   input  wire [`ZONE_W-1:0]  acc_zone,
   input  wire [AW-1:0]       acc_addr,
   input  wire [DW-1:0]       acc_wdata,
   output wire                acc_done,
   output reg  [DW-1:0]       acc_rdata,
   output wire                acc_rejected,
   // Configuration
   input  wire                mode_wr_en,
   input  wire                mode_wr_data,
   output reg                 boot_map_mode,
   output wire                boot_rom_select,
   input  wire                tim_wr_en,
   input  wire [`ZONE_W-1:0]  tim_wr_zone,
   input  wire [`TIM_W-1:0]   tim_wr_data,
   // Pins
   input  wire                boot_map_mode_select,
   input  wire                bus_hold_request_n,
   output reg                 bus_hold_grant_n,
   input  wire                target_ready,
   output reg  [AW-1:0]       ext_addr_bus,
   output wire                ext_addr_oe_n,
   input  wire [DW-1:0]       ext_data_in,
   output reg  [DW-1:0]       ext_data_out,
   output wire                ext_data_oe_n,
   output reg                 zone01_select_n,
   output reg                 zone_two_select_n,
   output reg                 zone67_select_n,
   output reg                 write_strobe_n,
   output reg                 read_strobe_n,
   output reg                 read_not_write,
   output wire                ctrl_oe_n
);
   //--------------------------------------------------
   // States
   //--------------------------------------------------
   localparam S_IDLE  = 6'b000001;
   localparam S_FETCH = 6'b000010;
   localparam S_LEAD  = 6'b000100;
   localparam S_ACT   = 6'b001000;
   localparam S_TRAIL = 6'b010000;
   localparam S_HOLD  = 6'b100000;

   reg  [5:0]               state;
   reg  [`TIM_FIELD_W-1:0]  cnt;
   reg                      cur_write;
   reg  [`ZONE_W-1:0]       cur_zone;
   reg                      in_reset;
   reg                      hold_s1, hold_s2;
   reg                      rdy_s1, rdy_s2, rdy_s3;
   reg                      mode_s1, mode_s2;
   wire [`TIM_W-1:0]        tim;

   function zone_external;
      input [`ZONE_W-1:0] z;
      input               mode;
      begin
         case (z)
            `ZONE_0, `ZONE_1, `ZONE_2, `ZONE_6 : zone_external = 1'b1;
            `ZONE_7 : zone_external = mode;
            default : zone_external = 1'b0;
         endcase
      end
   endfunction

   function [`TIM_FIELD_W-1:0] tfield;
      input [`TIM_W-1:0] t;
      input integer      lsb;
      begin
         tfield = t[lsb +: `TIM_FIELD_W];
      end
   endfunction

   // Timing word follows the latched zone once an access is taken
   wire [`ZONE_W-1:0]       tim_addr = (state == S_IDLE) ? acc_zone : cur_zone;

   zone_timing_mem u_tim (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .wr_en   (tim_wr_en),
      .wr_addr (tim_wr_zone),
      .wr_data (tim_wr_data),
      .rd_addr (tim_addr),
      .rd_data (tim)
   );

   //--------------------------------------------------
   // Pin synchronisers
   //--------------------------------------------------
   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hold_s1 <= 1'b1;
         hold_s2 <= 1'b1;
         rdy_s1  <= 1'b0;
         rdy_s2  <= 1'b0;
         rdy_s3  <= 1'b0;
      end
      else
      begin
         hold_s1 <= bus_hold_request_n;
         hold_s2 <= hold_s1;
         rdy_s1  <= target_ready;
         rdy_s2  <= rdy_s1;
         rdy_s3  <= rdy_s2;
      end
   end

   // Mode pin runs through reset so its level is ready at release
   always @(posedge clk_sys)
   begin
      mode_s1 <= boot_map_mode_select;
      mode_s2 <= mode_s1;
   end

   // Async mode adds a qualifying stage: ready must be seen twice
   wire rdy_seen = tim[`TIM_RDY_ASYNC] ? (rdy_s2 & rdy_s3) : rdy_s2;
   wire rdy_ok   = ~tim[`TIM_USE_RDY] | rdy_seen;

   //--------------------------------------------------
   // Mode latch
   //--------------------------------------------------
   // Tracks pin for the first cycle after reset, then software only
   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         in_reset      <= 1'b1;
         boot_map_mode <= 1'b0;
      end
      else
      begin
         in_reset <= 1'b0;
         if (in_reset)
            boot_map_mode <= mode_s2;
         else if (mode_wr_en)
            boot_map_mode <= mode_wr_data;
      end
   end

   wire req_ext = acc_req & zone_external(acc_zone, boot_map_mode);
   assign boot_rom_select = acc_req & (acc_zone == `ZONE_7) & ~boot_map_mode;
   assign acc_rejected    = acc_req & ~zone_external(acc_zone, boot_map_mode);

   //--------------------------------------------------
   // Access sequencer
   //--------------------------------------------------
   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state     <= S_IDLE;
         cnt       <= 4'h0;
         cur_write <= 1'b0;
         cur_zone  <= 3'h0;
         acc_rdata <= 16'h0000;
      end
      else
      begin
         case (state)
            S_IDLE:
               // Pending access is served before the bus is handed over
               if (req_ext)
               begin
                  cur_write <= acc_write;
                  cur_zone  <= acc_zone;
                  state     <= S_FETCH;
               end
               else if (!hold_s2)
                  state <= S_HOLD;
            S_FETCH:
            begin
               cnt   <= tfield(tim, `TIM_LEAD_LSB);
               state <= S_LEAD;
            end
            S_LEAD:
               if (cnt <= 4'h1)
               begin
                  cnt   <= tfield(tim, `TIM_ACT_LSB);
                  state <= S_ACT;
               end
               else
                  cnt <= cnt - 4'h1;
            S_ACT:
               if (cnt > 4'h1)
                  cnt <= cnt - 4'h1;
               else if (rdy_ok)
               begin
                  if (!cur_write)
                     acc_rdata <= ext_data_in;
                  cnt   <= tfield(tim, `TIM_TRAIL_LSB);
                  state <= S_TRAIL;
               end
            S_TRAIL:
               if (cnt <= 4'h1)
                  state <= S_IDLE;
               else
                  cnt <= cnt - 4'h1;
            S_HOLD:
               if (hold_s2)
                  state <= S_IDLE;
            default:
               state <= S_IDLE;
         endcase
      end
   end

   assign acc_done = (state == S_TRAIL) && (cnt <= 4'h1);

   //--------------------------------------------------
   // Pin drivers
   //--------------------------------------------------
   wire busy = (state == S_LEAD) | (state == S_ACT) | (state == S_TRAIL);

   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bus_hold_grant_n  <= 1'b1;
         ext_addr_bus      <= 19'h00000;
         ext_data_out      <= 16'h0000;
         zone01_select_n   <= 1'b1;
         zone_two_select_n <= 1'b1;
         zone67_select_n   <= 1'b1;
         write_strobe_n    <= 1'b1;
         read_strobe_n     <= 1'b1;
         read_not_write    <= 1'b1;
      end
      else
      begin
         bus_hold_grant_n <= ~((state == S_HOLD) & ~hold_s2);
         if (state == S_FETCH)
         begin
            ext_addr_bus <= acc_addr;
            ext_data_out <= acc_wdata;
         end
         zone01_select_n   <= ~(busy & (cur_zone[2:1] == 2'b00));
         zone_two_select_n <= ~(busy & (cur_zone == `ZONE_2));
         zone67_select_n   <= ~(busy & (cur_zone[2:1] == 2'b11));
         // Strobes only during active phase; one direction per access
         write_strobe_n <= ~((state == S_ACT) & cur_write);
         read_strobe_n  <= ~((state == S_ACT) & ~cur_write);
         read_not_write <= ~(busy & cur_write);
      end
   end

   // Everything floats while the bus is handed over
   assign ctrl_oe_n     = ~bus_hold_grant_n;
   assign ext_addr_oe_n = ~bus_hold_grant_n;
   assign ext_data_oe_n = ~(bus_hold_grant_n & busy & cur_write);
endmodule

// ---- core/zone_timing_mem.v ----
/*
 * Small register file holding one timing word per zone.
 * Assumes writes and reads on clk_sys; read data is registered.
 */
`timescale 1ns/1ps
`include "ext_if_consts.vh"

module zone_timing_mem #(
   parameter WIDTH = `TIM_W,
   parameter DEPTH = `NUM_ZONES,
   parameter AW    = `ZONE_W
)(
   input  wire             clk_sys,
   input  wire             sys_rst,
   input  wire             wr_en,
   input  wire [AW-1:0]    wr_addr,
   input  wire [WIDTH-1:0] wr_data,
   input  wire [AW-1:0]    rd_addr,
   output reg  [WIDTH-1:0] rd_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   integer         i;

   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (i = 0; i < DEPTH; i = i + 1)
            mem[i] <= `TIM_RESET;
         rd_data <= `TIM_RESET;
      end
      else
      begin
         if (wr_en)
            mem[wr_addr] <= wr_data;
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// ---- dv/ext_if_properties.sv ----
/* Pin checker for external_interface.
   Bound to the design; sees its ports only. */
`timescale 1ns/1ps
module ext_if_properties (
   input wire       clk_sys,
   input wire       sys_rst,
   input wire       acc_req,
   input wire [2:0] acc_zone,
   input wire       acc_rejected,
   input wire       bus_hold_request_n,
   input wire       bus_hold_grant_n,
   input wire       ext_addr_oe_n,
   input wire       ext_data_oe_n,
   input wire       ctrl_oe_n,
   input wire       zone01_select_n,
   input wire       zone_two_select_n,
   input wire       zone67_select_n,
   input wire       write_strobe_n,
   input wire       read_strobe_n,
   input wire       read_not_write
);
   wire sel = ~(zone01_select_n & zone_two_select_n & zone67_select_n);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_strobe_excl: assert property (read_strobe_n | write_strobe_n)
      else $error("both strobes low");
   a_rnw_write: assert property (!write_strobe_n |-> !read_not_write && sel)
      else $error("write strobe outside write cycle");
   a_rnw_read: assert property (!read_strobe_n |-> read_not_write && sel)
      else $error("read strobe outside read cycle");
   a_zone01_sel: assert property (
      $fell(zone01_select_n) |-> acc_req && acc_zone[2:1] == 2'h0) else $error("zone 0/1 select");
   a_zone2_sel: assert property (
      $fell(zone_two_select_n) |-> acc_req && acc_zone == 3'h2) else $error("zone 2 select");
   a_zone67_sel: assert property (
      $fell(zone67_select_n) |-> acc_req && acc_zone[2:1] == 2'h3) else $error("zone 6/7 select");
   a_grant_float: assert property (
      !bus_hold_grant_n |-> ext_addr_oe_n && ext_data_oe_n && ctrl_oe_n) else $error("bus driven");
   a_grant_idle: assert property (
      $fell(bus_hold_grant_n) |-> !sel && !$past(bus_hold_request_n, 2)
         && (!$past(acc_req, 2) || $past(acc_rejected, 2))) else $error("early grant");
   a_grant_drop: assert property (
      $rose(bus_hold_request_n) |-> ##[1:6] bus_hold_grant_n) else $error("grant kept");
endmodule

bind external_interface ext_if_properties checker_inst (.*);

// ---- dv/ext_mem_model.sv ----
/* Far-side memory with a ready line.
   Assumes the combined chip select and the design's pin outputs. */
`timescale 1ns/1ps
module ext_mem_model #(parameter WAIT = 6) (
   input  wire        clk_sys,
   input  wire        sel_n,
   input  wire        write_strobe_n,
   input  wire        read_not_write,
   input  wire [3:0]  addr,
   input  wire [15:0] wdata,
   output wire [15:0] rdata,
   output wire        ready
);
   logic [15:0] mem [0:15];
   logic [3:0]  cnt = 4'h0;
   always @(posedge clk_sys)
   begin
      if (!write_strobe_n)
         mem[addr] <= wdata;
      cnt <= sel_n ? 4'h0 : cnt + {3'h0, cnt != 4'hf};
   end
   // Pull-ups when not selected
   assign rdata = (!sel_n && read_not_write) ? mem[addr] : 16'hffff;
   assign ready = sel_n | (cnt >= WAIT);
endmodule

// ---- dv/tb.sv ----
/* Testbench for external_interface: timing, zones, ready, mode, hold.
   Assumes the memory model on the pins. */
`timescale 1ns/1ps
module tb;
   logic        clk_sys = 1'h0, sys_rst = 1'h1, acc_req = 1'h0, acc_write = 1'h0;
   logic        mode_wr_en = 1'h0, mode_wr_data = 1'h0, tim_wr_en = 1'h0;
   logic        boot_map_mode_select = 1'h1, bus_hold_request_n = 1'h1;
   logic        req_q = 1'h0;
   logic [2:0]  acc_zone = 3'h0, tim_wr_zone = 3'h0, sel_seen;
   logic [18:0] acc_addr = 19'h0, addr_seen;
   logic [15:0] acc_wdata = 16'h0, rd;
   logic [13:0] tim_wr_data = 14'h0;
   logic [2:0]  zl [4] = '{3'h0, 3'h2, 3'h6, 3'h7};
   logic [2:0]  zs [4] = '{3'h1, 3'h2, 3'h4, 3'h4};
   wire  [15:0] acc_rdata, ext_data_in, ext_data_out;
   wire  [18:0] ext_addr_bus;
   wire         acc_done, acc_rejected, boot_map_mode, boot_rom_select, target_ready;
   wire         bus_hold_grant_n, ext_addr_oe_n, ext_data_oe_n, ctrl_oe_n;
   wire         zone01_select_n, zone_two_select_n, zone67_select_n;
   wire         write_strobe_n, read_strobe_n, read_not_write;
   int          n_errors = 0, samples_checked = 0, lead, act, trail;

   external_interface DUT (.*);
   ext_mem_model mem_model (.clk_sys(clk_sys), .write_strobe_n(write_strobe_n),
      .sel_n(zone01_select_n & zone_two_select_n & zone67_select_n),
      .read_not_write(read_not_write), .addr(ext_addr_bus[3:0]), .wdata(ext_data_out),
      .rdata(ext_data_in), .ready(target_ready));

   initial
      forever #2 clk_sys = ~clk_sys;

   // ----------------------------------------
   // Strobe phase monitor
   // ----------------------------------------
   // Counters clear on each new request, before any select can fall
   always @(posedge clk_sys)
   begin
      req_q <= acc_req;
      if (acc_req && !req_q)
      begin
         lead <= 0;
         act <= 0;
         trail <= 0;
         sel_seen <= 3'h0;
      end
      else if (!(zone01_select_n & zone_two_select_n & zone67_select_n))
      begin
         sel_seen <= sel_seen | ~{zone67_select_n, zone_two_select_n, zone01_select_n};
         if (!(read_strobe_n & write_strobe_n))
         begin
            act <= act + 1;
            addr_seen <= ext_addr_bus;
         end
         else if (act == 0)
            lead <= lead + 1;
         else
            trail <= trail + 1;
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic test_done;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic over(input string what);
      n_errors++;
      $display("Error %s expected response seen timeout", what);
      test_done();
   endtask
   task automatic tchk(input int l, input int a, input int t);
      chk("lead cycles", l, lead);
      chk("active cycles", a, act);
      chk("trail cycles", t, trail);
   endtask
   task automatic set_tim(input logic [2:0] z, input logic [13:0] w);
      tim_wr_en <= 1'h1;
      tim_wr_zone <= z;
      tim_wr_data <= w;
      @(posedge clk_sys);
      tim_wr_en <= 1'h0;
      @(posedge clk_sys);
   endtask
   task automatic acc(input logic w, input logic [2:0] z, input logic [18:0] a,
      input logic [15:0] d);
      int k;
      acc_req <= 1'h1;
      acc_write <= w;
      acc_zone <= z;
      acc_addr <= a;
      acc_wdata <= d;
      for (k = 0; k < 100; k++)
      begin
         @(posedge clk_sys);
         #1;
         if (acc_done === 1'h1)
            break;
      end
      rd = acc_rdata;
      @(posedge clk_sys);
      acc_req <= 1'h0;
      if (k == 100)
         over("access done");
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic grant_is(input logic v);
      int k;
      for (k = 0; k < 20 && bus_hold_grant_n !== v; k++)
         @(posedge clk_sys);
      if (k == 20)
         over("hold grant");
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'h0;
      repeat (3) @(posedge clk_sys);
      chk("mode latched", 19'h1, boot_map_mode);
      boot_map_mode_select <= 1'h0;
      repeat (4) @(posedge clk_sys);
      chk("mode kept", 19'h1, boot_map_mode);
      $display("mode latch test done");
      set_tim(3'h1, 14'h0432);
      acc(1'h1, 3'h1, 19'h5a5a5, 16'hc3e1);
      tchk(2, 3, 4);
      chk("address", 19'h5a5a5, addr_seen);
      acc(1'h0, 3'h1, 19'h5a5a5, 16'h0);
      tchk(2, 3, 4);
      chk("read data", 19'hc3e1, rd);
      $display("strobe timing test done");
      foreach (zl[i])
      begin
         acc(1'h1, zl[i], 19'h10, 16'h1234);
         chk("selects", zs[i], sel_seen);
      end
      $display("zone select test done");
      set_tim(3'h2, 14'h1114);
      acc(1'h0, 3'h2, 19'h3, 16'h0);
      chk("ready waits", 19'h1, act > 1);
      set_tim(3'h2, 14'h3114);
      acc(1'h0, 3'h2, 19'h3, 16'h0);
      chk("async ready waits", 19'h1, act > 1);
      $display("ready test done");
      fork
         acc(1'h1, 3'h0, 19'h7, 16'h0bad);
         begin
            repeat (3) @(posedge clk_sys);
            bus_hold_request_n <= 1'h0;
         end
      join
      tchk(1, 1, 1);
      grant_is(1'h0);
      @(posedge clk_sys);
      chk("released", 19'h7, {ext_addr_oe_n, ext_data_oe_n, ctrl_oe_n});
      bus_hold_request_n <= 1'h1;
      grant_is(1'h1);
      // Hold pin lowered a cycle before a request; the request reaches the sequencer first, so the access goes first
      bus_hold_request_n <= 1'h0;
      @(posedge clk_sys);
      acc(1'h1, 3'h0, 19'h9, 16'h0001);
      tchk(1, 1, 1);
      grant_is(1'h0);
      bus_hold_request_n <= 1'h1;
      grant_is(1'h1);
      $display("bus hold test done");
      mode_wr_en <= 1'h1;
      mode_wr_data <= 1'h0;
      @(posedge clk_sys);
      mode_wr_en <= 1'h0;
      @(posedge clk_sys);
      acc_zone <= 3'h7;
      acc_req <= 1'h1;
      repeat (2) @(posedge clk_sys);
      chk("mode written", 19'h0, boot_map_mode);
      chk("zone 7 refused", 19'h1, acc_rejected);
      chk("boot rom", 19'h1, boot_rom_select);
      acc_req <= 1'h0;
      $display("boot map test done");
      test_done();
   end
endmodule

// ---- include/ext_if_consts.vh ----
/*
 * Constants for the external memory interface: zones, timing field
 * layout, configuration bit positions and widths.
 * Assumes inclusion by bare name from the core design files.
 */
`ifndef EXT_IF_CONSTS_VH
`define EXT_IF_CONSTS_VH

`define ADDR_W          19
`define DATA_W          16
`define ZONE_W          3
`define ZONE_0          3'h0
`define ZONE_1          3'h1
`define ZONE_2          3'h2
`define ZONE_6          3'h6
`define ZONE_7          3'h7
`define NUM_ZONES       8
// Zone timing word: lead [3:0], active [7:4], trail [11:8], ready use [12], async [13]
`define TIM_W           14
`define TIM_LEAD_LSB    0
`define TIM_ACT_LSB     4
`define TIM_TRAIL_LSB   8
`define TIM_FIELD_W     4
`define TIM_USE_RDY     12
`define TIM_RDY_ASYNC   13
`define TIM_RESET       14'h0111
`endif
